//--- inc/tcr_pkg.sv
// Functional notes
// - mode bits pick timer, event, pulse width
// - preload low buffered, high commits both bytes
// - reading count high latches low byte
// - overflow reloads preload and sets flag
// - pulse width counts between edge and return
// - one measurement, rearmed by enable write
// - pulse width overflow reloads like others
// - counting only while enable set
// - edge select 0 rising, 1 falling
// - preload write when stopped loads counter too
// - count high read blocks the count clock
// - converter select bit picks counter or converter
// - converter counter A system clock in timer and pulse width modes (edges in event mode), B oscillator
// - converter mode bit picks resistor network
// - overflow source bit picks A or B
// - selected overflow sets flag, stops, clears enable
// - converter high write loads counter with buffer
// - converter high read latches that low byte
// - byte registers locked while converter runs
// - bit 3 enables low voltage detector
package tcr_pkg;
    localparam logic [7:0] IDX_CNT_HI = 8'h20;
    localparam logic [7:0] IDX_CNT_LO = 8'h21;
    localparam logic [7:0] IDX_CTRL = 8'h22;
    localparam logic [7:0] IDX_PL_HI = 8'h23;
    localparam logic [7:0] IDX_PL_LO = 8'h24;
    localparam logic [7:0] IDX_CONV = 8'h25;
    localparam logic [7:0] IDX_IRQ = 8'h2F;
    localparam int BIT_EDGE = 3;
    localparam int BIT_EN = 4;
    localparam int BIT_MODE = 5;
    localparam int BIT_OVSRC = 0;
    localparam int BIT_CONV = 1;
    localparam int BIT_NET = 2;
    localparam int BIT_LVD_EN = 3;
    localparam int BIT_LVD_LOW = 4;
    localparam int BIT_FLAG = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] CONV_RST = 4'h0;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [1:0] MODE_TIMER = 2'b10;
    localparam logic [1:0] MODE_EVENT = 2'b01;
    localparam logic [1:0] MODE_PW = 2'b11;
    typedef enum logic [1:0] {PW_WAIT, PW_RUN, PW_DONE} tcr_pw_t;
endpackage

//--- hw/tcr_top.sv
`timescale 1ns/1ps
module tcr_top (
    input wire logic ref_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic rc_osc_input, // rc oscillator / event pin
    input wire logic lowvolt_low, // detector says battery low
    output logic overflow_irq_flag, // sticky overflow flag
    output logic lowvolt_detect_enable, // detector on
    output logic reference_resistor_pin, // reference network runs
    output logic sensor_resistor_pin // sensor network runs
);
    import tcr_pkg::*;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic wp_q;
    logic [7:0] widx_q;
    logic [31:0] hrdata_q;
    logic hready_q;
    wire ap = hsel & htrans[1] & hready;
    wire [7:0] aidx = (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'hFF;
    wire rd = ap & ~hwrite;
    wire [7:0] wdat = hwdata[7:0];
    wire wr_cnt_hi = wp_q & (widx_q == IDX_CNT_HI);
    wire wr_cnt_lo = wp_q & (widx_q == IDX_CNT_LO);
    wire wr_ctl = wp_q & (widx_q == IDX_CTRL);
    wire wr_pl_hi = wp_q & (widx_q == IDX_PL_HI);
    wire wr_pl_lo = wp_q & (widx_q == IDX_PL_LO);
    wire wr_conv = wp_q & (widx_q == IDX_CONV);
    wire wr_irq = wp_q & (widx_q == IDX_IRQ);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wp_q <= 1'b0;
            widx_q <= 8'h00;
            hready_q <= 1'b0;
        end else begin
            wp_q <= ap & hwrite;
            widx_q <= aidx;
            hready_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // control state
    // ----------------------------------------
    logic [7:0] ctl_q;
    logic [3:0] conv_q;
    logic irq_q;
    logic [15:0] cnt_a_q;
    logic [15:0] cnt_b_q;
    logic [15:0] pre_q;
    logic [7:0] wbuf_q;
    logic [7:0] rbuf_q;
    logic rc_q;
    logic pw_lvl_q;
    tcr_pw_t pw_q;
    tcr_pw_t pw_d;

    wire en = ctl_q[BIT_EN];
    wire [1:0] mode = ctl_q[BIT_MODE+1:BIT_MODE];
    wire conv = conv_q[BIT_CONV];
    wire lock = conv & en;
    wire rise = rc_osc_input & ~rc_q;
    wire fall = ~rc_osc_input & rc_q;
    wire edge_act = ctl_q[BIT_EDGE] ? fall : rise;
    wire blk = rd & (aidx == IDX_CNT_HI);

    // ----------------------------------------
    // count ticks and overflow
    // ----------------------------------------
    wire pw_mode = ~conv & (mode == MODE_PW);
    wire pw_start = en & pw_mode & (pw_q == PW_WAIT) & edge_act;
    wire pw_end = pw_mode & (pw_q == PW_RUN) & (rc_osc_input != pw_lvl_q);
    wire src_a = (mode == MODE_TIMER) ? 1'b1 :
                 (mode == MODE_EVENT) ? edge_act :
                 (mode == MODE_PW) ? (conv | ((pw_q == PW_RUN) & ~pw_end)) : 1'b0;
    wire tick_a = en & ~blk & src_a;
    wire tick_b = conv & en & ~blk & edge_act;
    wire ovf_a = tick_a & (cnt_a_q == CNT_MAX);
    wire ovf_b = tick_b & (cnt_b_q == CNT_MAX);
    wire conv_stop = conv & (conv_q[BIT_OVSRC] ? ovf_b : ovf_a);
    wire irq_set = conv ? conv_stop : ovf_a;

    always_comb begin
        pw_d = pw_q;
        case (pw_q)
            PW_WAIT: begin
                if (pw_start) begin
                    pw_d = PW_RUN;
                end
            end
            PW_RUN: begin
                if (pw_end) begin
                    pw_d = PW_DONE;
                end
            end
            PW_DONE: pw_d = PW_DONE;
            default: pw_d = PW_WAIT;
        endcase
        if (wr_ctl & wdat[BIT_EN]) begin
            pw_d = PW_WAIT;
        end
    end

    // ----------------------------------------
    // counters, preload, buffers
    // ----------------------------------------
    wire [15:0] wword = {wdat, wbuf_q};
    wire ld_a = ~lock & (wr_cnt_hi | (~conv & wr_pl_hi & ~en));
    wire ld_b = ~lock & conv & wr_pl_hi;
    wire [15:0] cnt_a_d = ld_a ? wword :
                          (ovf_a & ~conv) ? pre_q :
                          tick_a ? 16'(cnt_a_q + 16'h0001) : cnt_a_q;
    wire [15:0] cnt_b_d = ld_b ? wword : tick_b ? 16'(cnt_b_q + 16'h0001) : cnt_b_q;
    wire [15:0] pre_d = (~conv & wr_pl_hi) ? wword : pre_q;
    wire [7:0] wbuf_d = (~lock & (wr_cnt_lo | wr_pl_lo)) ? wdat : wbuf_q;
    wire [7:0] rbuf_d = (rd & ~lock & (aidx == IDX_CNT_HI)) ? cnt_a_q[7:0] :
                        (rd & ~lock & conv & (aidx == IDX_PL_HI)) ? cnt_b_q[7:0] : rbuf_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_a_q <= CNT_RST;
            cnt_b_q <= CNT_RST;
            pre_q <= CNT_RST;
            wbuf_q <= 8'h00;
            rbuf_q <= 8'h00;
            rc_q <= 1'b0;
            pw_lvl_q <= 1'b0;
            pw_q <= PW_WAIT;
        end else begin
            cnt_a_q <= cnt_a_d;
            cnt_b_q <= cnt_b_d;
            pre_q <= pre_d;
            wbuf_q <= wbuf_d;
            rbuf_q <= rbuf_d;
            rc_q <= rc_osc_input;
            pw_lvl_q <= pw_start ? rc_osc_input : pw_lvl_q;
            pw_q <= pw_d;
        end
    end

    // ----------------------------------------
    // control registers and flag
    // ----------------------------------------
    wire [7:0] ctl_w = wr_ctl ? {1'b0, wdat[6:3], 3'b000} : ctl_q;
    wire en_clr = conv_stop | pw_end;
    wire [7:0] ctl_d = en_clr ? (ctl_w & ~(8'h01 << BIT_EN)) : ctl_w;
    wire [3:0] conv_d = wr_conv ? wdat[3:0] : conv_q;
    wire irq_d = irq_set | (wr_irq ? wdat[BIT_FLAG] : irq_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= CTRL_RST;
            conv_q <= CONV_RST;
            irq_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            conv_q <= conv_d;
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------
    // read mux and outputs
    // ----------------------------------------
    wire lvd_low = conv_q[BIT_LVD_EN] & lowvolt_low;
    wire [7:0] rd_val = (aidx == IDX_CNT_HI) ? (lock ? 8'h00 : cnt_a_q[15:8]) :
                        (aidx == IDX_CNT_LO) ? (lock ? 8'h00 : rbuf_q) :
                        (aidx == IDX_CTRL) ? ctl_q :
                        (aidx == IDX_PL_HI) ? (lock ? 8'h00 : conv ? cnt_b_q[15:8] : pre_q[15:8]) :
                        (aidx == IDX_PL_LO) ? (lock ? 8'h00 : conv ? rbuf_q : pre_q[7:0]) :
                        (aidx == IDX_CONV) ? {3'b000, lvd_low, conv_q} :
                        (aidx == IDX_IRQ) ? {3'b000, irq_q, 4'h0} : 8'h00;
    logic lvd_q;
    logic reference_resistor_pin_q;
    logic sensor_resistor_pin_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata_q <= 32'h00000000;
            lvd_q <= 1'b0;
            reference_resistor_pin_q <= 1'b0;
            sensor_resistor_pin_q <= 1'b0;
        end else begin
            hrdata_q <= rd ? {24'h000000, rd_val} : 32'h00000000;
            lvd_q <= conv_d[BIT_LVD_EN];
            reference_resistor_pin_q <= conv_d[BIT_CONV] & ctl_d[BIT_EN] & ~conv_d[BIT_NET];
            sensor_resistor_pin_q <= conv_d[BIT_CONV] & ctl_d[BIT_EN] & conv_d[BIT_NET];
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp = 1'b0;
    assign overflow_irq_flag = irq_q;
    assign lowvolt_detect_enable = lvd_q;
    assign reference_resistor_pin = reference_resistor_pin_q;
    assign sensor_resistor_pin = sensor_resistor_pin_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_ovf_reload;
        (ovf_a & ~conv & ~ld_a) |=> (cnt_a_q == $past(pre_q)) && irq_q;
    endproperty
    a_ovf_reload: assert property (p_ovf_reload) else $error("overflow did not reload");

    sequence s_conv_ovf;
        conv_stop & ~wr_ctl;
    endsequence
    property p_conv_stop;
        s_conv_ovf |=> ~en && irq_q ##1 $stable(cnt_a_q) && $stable(cnt_b_q);
    endproperty
    a_conv_stop: assert property (p_conv_stop) else $error("converter did not stop");

    property p_en_sw_only;
        ($fell(en) && ~$past(conv) && $past(mode) != MODE_PW) |-> $past(wr_ctl);
    endproperty
    a_en_sw_only: assert property (p_en_sw_only) else $error("enable cleared by hardware");

    property p_rd_latch;
        (blk & ~lock) |=> rbuf_q == $past(cnt_a_q[7:0]);
    endproperty
    a_rd_latch: assert property (p_rd_latch) else $error("low byte not latched");

    property p_pl_lo;
        wr_pl_lo |=> pre_q == $past(pre_q);
    endproperty
    a_pl_lo: assert property (p_pl_lo) else $error("preload changed by low write");

    property p_pl_off;
        (wr_pl_hi & ~en & ~conv) |=> cnt_a_q == pre_q;
    endproperty
    a_pl_off: assert property (p_pl_off) else $error("stopped counter not loaded");

    property p_blk;
        (blk & ~wp_q) |=> cnt_a_q == $past(cnt_a_q);
    endproperty
    a_blk: assert property (p_blk) else $error("counter moved during high read");

    property p_pw_end;
        (pw_end & ~wr_ctl) |=> ~en ##1 (pw_q == PW_DONE || $past(wr_ctl));
    endproperty
    a_pw_end: assert property (p_pw_end) else $error("pulse width did not finish");

    property p_flag_sticky;
        (irq_q & ~wr_irq) |=> irq_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_lock;
        (rd & lock & (aidx == IDX_CNT_HI)) |=> hrdata == 32'h00000000;
    endproperty
    a_lock: assert property (p_lock) else $error("locked register readable");

    // ----------------------------------------
    // counting and converter checks
    // ----------------------------------------
    // a write data phase may load the counters, so those cycles are left out below
    property p_timer_tick;
        (en & ~conv & (mode == MODE_TIMER) & ~blk & ~wp_q & (cnt_a_q != CNT_MAX)) |=>
            cnt_a_q == 16'($past(cnt_a_q) + 16'h0001);
    endproperty
    a_timer_tick: assert property (p_timer_tick) else $error("timer missed a tick");

    sequence s_no_edge;
        ctl_q[BIT_EDGE] ? (rc_osc_input | ~rc_q) : (~rc_osc_input | rc_q);
    endsequence
    property p_edge_sel;
        (en & ~conv & (mode == MODE_EVENT) & ~wp_q) ##0 s_no_edge |=> $stable(cnt_a_q);
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("event counted on wrong edge");

    property p_pw_wait;
        (pw_mode & (pw_q == PW_WAIT) & ~wp_q) |=> $stable(cnt_a_q);
    endproperty
    a_pw_wait: assert property (p_pw_wait) else $error("pulse width counted before edge");

    property p_pw_hold;
        (pw_mode & (pw_q == PW_DONE) & ~wp_q) |=> $stable(cnt_a_q);
    endproperty
    a_pw_hold: assert property (p_pw_hold) else $error("pulse width result moved");

    // preload write while running must leave the count alone
    property p_pl_on;
        (wr_pl_hi & en & ~conv & (mode == MODE_TIMER) & ~blk & (cnt_a_q != CNT_MAX)) |=>
            cnt_a_q == 16'($past(cnt_a_q) + 16'h0001);
    endproperty
    a_pl_on: assert property (p_pl_on) else $error("running counter reloaded by preload write");

    property p_b_idle;
        (~conv & ~wp_q) |=> $stable(cnt_b_q);
    endproperty
    a_b_idle: assert property (p_b_idle) else $error("second counter moved outside converter");

    property p_b_load;
        (wr_pl_hi & conv & ~en) |=> cnt_b_q == {$past(wdat), $past(wbuf_q)};
    endproperty
    a_b_load: assert property (p_b_load) else $error("second counter not loaded");

    property p_b_latch;
        (rd & conv & ~en & (aidx == IDX_PL_HI)) |=> rbuf_q == $past(cnt_b_q[7:0]);
    endproperty
    a_b_latch: assert property (p_b_latch) else $error("second low byte not latched");

    sequence s_conv_run;
        conv & en & ~conv_stop & ~wp_q;
    endsequence
    property p_net_ref;
        s_conv_run ##0 (~conv_q[BIT_NET]) |=> reference_resistor_pin & ~sensor_resistor_pin;
    endproperty
    a_net_ref: assert property (p_net_ref) else $error("reference network not driven");

    property p_net_sen;
        s_conv_run ##0 conv_q[BIT_NET] |=> sensor_resistor_pin & ~reference_resistor_pin;
    endproperty
    a_net_sen: assert property (p_net_sen) else $error("sensor network not driven");

    property p_lvd;
        lowvolt_detect_enable == conv_q[BIT_LVD_EN];
    endproperty
    a_lvd: assert property (p_lvd) else $error("detector enable differs from control bit");

    // only the selected counter may raise the flag while converting
    property p_ovsrc;
        (conv & ~irq_q & ~wr_irq & ~conv_stop) |=> ~irq_q;
    endproperty
    a_ovsrc: assert property (p_ovsrc) else $error("flag raised by unselected counter");
endmodule

//--- sim/tcr_rc_model.sv
`timescale 1ns/1ps
module tcr_rc_model #(parameter int HALF = 3) (
    input wire logic ref_clk, // system clock
    input wire logic run, // a resistor network is powered
    input wire logic level, // pin level while no network runs
    output logic rc_osc_input // rc pin
);
    int cnt = 0;
    logic osc = 1'b0;
    // oscillates only while a network is driven, so no edges leak in between runs
    always @(posedge ref_clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            osc <= ~osc;
        end
    end
    assign rc_osc_input = run ? osc : level;
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import tcr_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, lvl = 1'b0, lvd_low = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic hreadyout, hresp, flag, lvd_en, ref_pin, sen_pin, rc;
    logic [7:0] q;
    logic [15:0] v, g, g2;
    logic [3:0] cfg;
    int err_total = 0, check_count = 0, n, k;
    always #5 ref_clk = ~ref_clk;
    tcr_top tcr_top_inst (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rc_osc_input(rc), .lowvolt_low(lvd_low),
        .overflow_irq_flag(flag), .lowvolt_detect_enable(lvd_en), .reference_resistor_pin(ref_pin),
        .sensor_resistor_pin(sen_pin));
    tcr_rc_model tcr_rc_model_inst (.ref_clk(ref_clk), .run(ref_pin | sen_pin), .level(lvl), .rc_osc_input(rc));
    // ----------------------------------------
    // bus access and checking
    // ----------------------------------------
    function automatic logic [15:0] ev_exp(int cnt, int edge_sel);
        return 16'(cnt + 1 - edge_sel);
    endfunction
    task automatic chk(string s, logic [15:0] e, logic [15:0] got);
        check_count++;
        if (got !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", s, e, got);
        end
    endtask
    task automatic bus(logic w, logic [7:0] i, logic [7:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, i, 2'b00};
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        q = hrdata[7:0];
        chk("hresp", 16'h0, {15'h0, hresp});
    endtask
    task automatic wr(logic [7:0] i, logic [7:0] d);
        bus(1'b1, i, d);
    endtask
    task automatic rd(logic [7:0] i);
        bus(1'b0, i, 8'h00);
    endtask
    task automatic rd16(logic [7:0] hi, logic [7:0] lo, output logic [15:0] r);
        rd(hi);
        r[15:8] = q;
        rd(lo);
        r[7:0] = q;
    endtask
    task automatic ld16(logic [7:0] hi, logic [7:0] lo, logic [15:0] val);
        wr(lo, val[7:0]);
        wr(hi, val[15:8]);
    endtask
    task automatic waitflag(int lim);
        n = 0;
        while (flag !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        chk("flag_set", 16'h1, {15'h0, flag});
    endtask
    task automatic print_verdict;
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        print_verdict;
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'hEFE6));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(IDX_CTRL);
        chk("ctrl_reset", {8'h0, CTRL_RST}, {8'h0, q});
        wr(IDX_CTRL, 8'h87);
        rd(IDX_CTRL);
        chk("ctrl_unused", 16'h0, {8'h0, q});
        rd(8'h30);
        chk("unmapped", 16'h0, {8'h0, q});
        v = {12'hFFF, 4'($urandom)};
        ld16(IDX_PL_HI, IDX_PL_LO, v);
        wr(IDX_PL_LO, 8'h00);
        rd16(IDX_CNT_HI, IDX_CNT_LO, g);
        chk("cnt_from_preload", v, g);
        wr(IDX_IRQ, 8'h00);
        wr(IDX_CTRL, {1'b0, MODE_TIMER, 5'b10000});
        waitflag(40);
        ld16(IDX_PL_HI, IDX_PL_LO, v);
        rd(IDX_CTRL);
        chk("timer_en_kept", 16'h0050, {8'h0, q});
        chk("flag_sticky", 16'h1, {15'h0, flag});
        wr(IDX_CTRL, 8'h00);
        wr(IDX_IRQ, 8'h00);
        @(negedge ref_clk);
        chk("flag_clear", 16'h0, {15'h0, flag});
        for (int e = 0; e < 2; e++) begin
            k = 3 + $urandom % 6;
            ld16(IDX_CNT_HI, IDX_CNT_LO, 16'h0000);
            wr(IDX_CTRL, {1'b0, MODE_EVENT, 1'b1, 1'(e), 3'b000});
            repeat (k) begin
                repeat (3) @(posedge ref_clk);
                lvl <= 1'b1;
                repeat (3) @(posedge ref_clk);
                lvl <= 1'b0;
            end
            repeat (3) @(posedge ref_clk);
            lvl <= 1'b1;
            repeat (4) @(posedge ref_clk);
            wr(IDX_CTRL, 8'h00);
            lvl <= 1'b0;
            rd16(IDX_CNT_HI, IDX_CNT_LO, g);
            chk("event_count", ev_exp(k, e), g);
        end
        k = 5 + $urandom % 10;
        ld16(IDX_CNT_HI, IDX_CNT_LO, 16'h0000);
        wr(IDX_CTRL, {1'b0, MODE_PW, 5'b10000});
        repeat (2) @(posedge ref_clk);
        lvl <= 1'b1;
        repeat (k) @(posedge ref_clk);
        lvl <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(IDX_CTRL);
        chk("pw_en_cleared", 16'h0060, {8'h0, q});
        rd16(IDX_CNT_HI, IDX_CNT_LO, g);
        chk("pw_width", 16'h1, 16'(g >= k - 2 && g <= k + 2));
        lvl <= 1'b1;
        repeat (k) @(posedge ref_clk);
        lvl <= 1'b0;
        rd16(IDX_CNT_HI, IDX_CNT_LO, g2);
        chk("pw_held", g, g2);
        for (int c = 0; c < 2; c++) begin
            cfg = c ? 4'hF : 4'h2;
            lvd_low <= 1'($urandom);
            wr(IDX_IRQ, 8'h00);
            wr(IDX_CONV, {4'h0, cfg});
            rd(IDX_CONV);
            chk("conv_read", {11'h0, cfg[3] & lvd_low, cfg}, {8'h0, q});
            ld16(IDX_CNT_HI, IDX_CNT_LO, c ? 16'h0000 : 16'hFFF0);
            ld16(IDX_PL_HI, IDX_PL_LO, c ? 16'hFFF0 : 16'h0000);
            wr(IDX_CTRL, 8'h50);
            @(negedge ref_clk);
            chk("net_pins", {14'h0, cfg[2], ~cfg[2]}, {14'h0, sen_pin, ref_pin});
            chk("lvd_enable", {15'h0, cfg[3]}, {15'h0, lvd_en});
            rd(IDX_CNT_HI);
            chk("locked_read", 16'h0, {8'h0, q});
            waitflag(400);
            rd(IDX_CTRL);
            chk("conv_stopped", 16'h0040, {8'h0, q});
            if (c == 0) begin
                rd16(IDX_PL_HI, IDX_PL_LO, g);
            end else begin
                rd16(IDX_CNT_HI, IDX_CNT_LO, g);
            end
            chk("other_counted", 16'h1, 16'(g != 16'h0000));
        end
        wr(IDX_CONV, 8'h00);
        print_verdict;
    end
endmodule
